// *** rcss_top.sv ***
// rcss_top: reset-time clock selection, reset release timing and run-time clock switch
// Summary of operation
// - switching on: power resets use config, others keep current
// - switching off: every reset uses configured source
// - reset out released after power-on and powerup delays
// - startup timer and lock wait overlap reset delay
// - fail monitor starts after release plus delay
// - delay: power-on both, brown-out powerup, others none
// - powerup delay 64 ms enabled, else zero
// - startup timer counts 1024 crystal periods
// - two-speed start runs fast RC in place of primary
// - switch and monitor enabled only when config 0
// - switching off: new select stored but unused, current shows config
// - switching off: request ignored, reads zero
// - equal selects: request cleared, switch aborted
// - valid switch clears lock and fail flag
// - start target, wait crystal timer, wait lock
// - wait ten new-clock cycles before changeover
// - changeover clears request, copies new to current
// - old source off, except kept slow RC, secondary
// - processor keeps running during switch
// - primary submode fixed by configuration only
module rcss_top #(
  parameter int unsigned POWERUP_TIMER_CYCLES = rcss_pkg::POWERUP_TIMER_CYC,
  parameter int unsigned POR_CYCLES = rcss_pkg::POR_CYC,
  parameter int unsigned MON_CYCLES = rcss_pkg::MON_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // reset causes, asynchronous levels
  input wire logic power_on_rst_i,
  input wire logic brownout_reset_i,
  input wire logic external_reset_pin_i,
  input wire logic watchdog_timeout_reset_i,
  input wire logic software_reset_i,
  // configuration, static
  input wire logic switch_monitor_cfg_i,
  input wire logic [2:0] initial_osc_select_cfg_i,
  input wire logic [1:0] primary_submode_cfg_i,
  input wire logic powerup_timer_en_cfg_i,
  input wire logic two_speed_cfg_i,
  // oscillator side
  input wire logic [3:0] osc_tick_i,
  input wire logic pll_lock_i,
  input wire logic clock_fail_i,
  input wire logic wdt_uses_slow_rc_i,
  input wire logic rtc_uses_slow_rc_i,
  // control outputs
  output logic system_reset_out_o,
  output logic exec_enable_o,
  output logic clock_fail_monitor_en_o,
  output logic [2:0] sys_clk_sel_o,
  output logic [3:0] osc_enable_o,
  output logic pll_enable_o,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  // ************************************************************
  // decoding helpers
  // ************************************************************
  function automatic logic [3:0] fam_of(input logic [2:0] s);
    logic [3:0] f;
    f = '0;
    case (s)
      rcss_pkg::SRC_PRI, rcss_pkg::SRC_PRI_PLL: f[rcss_pkg::FAM_PRI] = 1'b1;
      rcss_pkg::SRC_SEC: f[rcss_pkg::FAM_SEC] = 1'b1;
      rcss_pkg::SRC_SLOW: f[rcss_pkg::FAM_SLOW] = 1'b1;
      default: f[rcss_pkg::FAM_FAST] = 1'b1;
    endcase
    return f;
  endfunction : fam_of

  function automatic logic pll_of(input logic [2:0] s);
    return (s == rcss_pkg::SRC_FAST_PLL) || (s == rcss_pkg::SRC_PRI_PLL);
  endfunction : pll_of

  // crystal when secondary, or primary in a crystal submode
  function automatic logic xtal_of(input logic [2:0] s, input logic [1:0] sub);
    logic [3:0] f;
    logic p;
    f = fam_of(s);
    p = f[rcss_pkg::FAM_PRI];
    return (s == rcss_pkg::SRC_SEC) || (p && (sub == rcss_pkg::SUB_XT ||
      sub == rcss_pkg::SUB_HS));
  endfunction : xtal_of

  rcss_pkg::rcss_regs_t r_reg;
  rcss_pkg::rcss_regs_t r_next;

  logic sw_en;
  logic [4:0] ev;
  logic ev_any;
  logic [2:0] tgt;
  logic tk_hit;
  logic acc;
  logic wr_done;
  logic mapped;
  logic in_sw;

  // ************************************************************
  // combinational terms
  // ************************************************************
  assign sw_en = ~switch_monitor_cfg_i;
  assign ev = r_reg.rst_s2 & ~r_reg.rst_d;
  assign ev_any = (|ev) || (r_reg.st == rcss_pkg::ST_BOOT);
  assign tgt = (r_reg.st == rcss_pkg::ST_RST) ? r_reg.cur : r_reg.nsel;
  assign tk_hit = |(r_reg.tk_s2 & ~r_reg.tk_d & fam_of(tgt));
  assign acc = psel_i && penable_i;
  assign wr_done = acc && r_reg.pready && pwrite_i;
  assign mapped = (paddr_i == rcss_pkg::ADDR_CTRL) || (paddr_i == rcss_pkg::ADDR_UNLOCK) ||
    (paddr_i == rcss_pkg::ADDR_STAT);
  assign in_sw = (r_reg.st == rcss_pkg::ST_SW_OST) || (r_reg.st == rcss_pkg::ST_SW_LOCK) ||
    (r_reg.st == rcss_pkg::ST_SW_SET);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [2:0] src;
    logic [3:0] sfam;
    logic [31:0] powerup_timer;
    logic [31:0] word;
    logic sw_nx;
    src = '0;
    sfam = '0;
    powerup_timer = '0;
    word = '0;
    sw_nx = 1'b0;
    r_next = r_reg;
    // asynchronous inputs pass two flops before use
    r_next.rst_s1 = {software_reset_i, watchdog_timeout_reset_i, external_reset_pin_i,
      brownout_reset_i, power_on_rst_i};
    r_next.rst_s2 = r_reg.rst_s1;
    r_next.rst_d = r_reg.rst_s2;
    r_next.tk_s1 = osc_tick_i;
    r_next.tk_s2 = r_reg.tk_s1;
    r_next.tk_d = r_reg.tk_s2;
    r_next.lk_s1 = pll_lock_i;
    r_next.lk_s2 = r_reg.lk_s1;
    r_next.fl_s1 = clock_fail_i;
    r_next.fl_s2 = r_reg.fl_s1;

    // apb: one wait state, read data latched in the first access cycle
    r_next.pready = acc && !r_reg.pready;
    r_next.pslverr = acc && !r_reg.pready && !mapped;
    r_next.prdata = '0;
    if (acc && !r_reg.pready && !pwrite_i) begin
      case (paddr_i)
        rcss_pkg::ADDR_CTRL: begin
          word[rcss_pkg::CUR_LSB +: 3] = r_reg.cur;
          word[rcss_pkg::NEW_LSB +: 3] = r_reg.nsel;
          word[rcss_pkg::LOCK_BIT] = r_reg.lock;
          word[rcss_pkg::FAIL_BIT] = r_reg.cfail;
          word[rcss_pkg::SEC_BIT] = r_reg.sec_en;
          word[rcss_pkg::REQ_BIT] = r_reg.req && sw_en;
        end
        rcss_pkg::ADDR_UNLOCK: word = {30'h0, r_reg.arm_lo, r_reg.arm_hi};
        rcss_pkg::ADDR_STAT: begin
          word[2:0] = {r_reg.mon, r_reg.run, r_reg.rst_out};
          word[rcss_pkg::STAT_KIND_LSB +: 3] = r_reg.kind;
          word[rcss_pkg::STAT_FSM_LSB +: 3] = r_reg.st;
        end
        default: word = '0;
      endcase
      r_next.prdata = word;
    end

    // register writes; each unlock is spent by one write to its byte
    if (wr_done) begin
      case (paddr_i)
        rcss_pkg::ADDR_CTRL: begin
          if (pstrb_i[1] && r_reg.arm_hi) begin
            r_next.nsel = pwdata_i[rcss_pkg::NEW_LSB +: 3];
            r_next.arm_hi = 1'b0;
          end
          if (pstrb_i[0] && r_reg.arm_lo) begin
            r_next.req = sw_en && pwdata_i[rcss_pkg::REQ_BIT];
            r_next.sec_en = pwdata_i[rcss_pkg::SEC_BIT];
            if (!pwdata_i[rcss_pkg::FAIL_BIT]) begin
              r_next.cfail = 1'b0;
            end
            r_next.arm_lo = 1'b0;
          end
        end
        rcss_pkg::ADDR_UNLOCK: begin
          if (pwdata_i == rcss_pkg::KEY_HI) begin
            r_next.arm_hi = 1'b1;
          end
          if (pwdata_i == rcss_pkg::KEY_LO) begin
            r_next.arm_lo = 1'b1;
          end
        end
        default: r_next.arm_hi = r_reg.arm_hi;
      endcase
    end

    // monitor arms after release plus its start delay; a failure beats a register-write clear, not the switch-start clear
    if (sw_en && !r_reg.rst_out && !r_reg.mon) begin
      if (r_reg.mdly == 32'h0) begin
        r_next.mon = 1'b1;
      end else begin
        r_next.mdly = r_reg.mdly - 32'h1;
      end
    end
    if (r_reg.mon && r_reg.fl_s2) begin
      r_next.cfail = 1'b1;
    end

    // sequencing; code keeps running through the switch states
    case (r_reg.st)
      rcss_pkg::ST_RST: begin
        // reset delay, crystal timer and lock wait all run together
        if (r_reg.dly != 32'h0) begin
          r_next.dly = r_reg.dly - 32'h1;
        end else begin
          r_next.rst_out = 1'b0;
        end
        if (!r_reg.ost_done && tk_hit) begin
          r_next.osc_startup_timer = r_reg.osc_startup_timer + 10'h1;
          r_next.ost_done = (r_reg.osc_startup_timer == rcss_pkg::OST_LAST);
        end
        r_next.lock = pll_of(r_reg.cur) && r_reg.lk_s2;
        if (!r_reg.rst_out && r_reg.ost_done && (!pll_of(r_reg.cur) || r_reg.lk_s2)) begin
          r_next.run = 1'b1;
          r_next.st = rcss_pkg::ST_RUN;
        end
      end
      rcss_pkg::ST_RUN: begin
        r_next.lock = pll_of(r_reg.cur) && r_reg.lk_s2;
        if (r_reg.req && sw_en) begin
          if (r_reg.nsel == r_reg.cur) begin
            r_next.req = 1'b0;
          end else begin
            r_next.lock = 1'b0;
            r_next.cfail = 1'b0;
            r_next.osc_startup_timer = '0;
            r_next.settle = '0;
            // crystal timer only when the crystal has to be started
            r_next.ost_done = !xtal_of(r_reg.nsel, primary_submode_cfg_i) ||
              (|(r_reg.osc_en & fam_of(r_reg.nsel)));
            r_next.st = rcss_pkg::ST_SW_OST;
          end
        end
      end
      rcss_pkg::ST_SW_OST: begin
        if (r_reg.ost_done) begin
          r_next.st = rcss_pkg::ST_SW_LOCK;
        end else if (tk_hit) begin
          r_next.osc_startup_timer = r_reg.osc_startup_timer + 10'h1;
          r_next.ost_done = (r_reg.osc_startup_timer == rcss_pkg::OST_LAST);
        end
      end
      rcss_pkg::ST_SW_LOCK: begin
        if (!pll_of(r_reg.nsel) || r_reg.lk_s2) begin
          r_next.lock = pll_of(r_reg.nsel);
          r_next.st = rcss_pkg::ST_SW_SET;
        end
      end
      rcss_pkg::ST_SW_SET: begin
        if (tk_hit) begin
          r_next.settle = r_reg.settle + 4'h1;
          if (r_reg.settle == rcss_pkg::SETTLE_LAST) begin
            r_next.cur = r_reg.nsel;
            r_next.req = 1'b0;
            r_next.st = rcss_pkg::ST_RUN;
          end
        end
      end
      default: r_next.st = rcss_pkg::ST_RST;
    endcase

    // reset events win over everything else
    if (ev_any) begin
      if (sw_en && !ev[0] && !ev[1] && r_reg.st != rcss_pkg::ST_BOOT) begin
        src = r_reg.cur;
      end else begin
        src = initial_osc_select_cfg_i;
      end
      sfam = fam_of(src);
      if (two_speed_cfg_i && sfam[rcss_pkg::FAM_PRI]) begin
        src = rcss_pkg::SRC_FAST;
      end
      powerup_timer = powerup_timer_en_cfg_i ? POWERUP_TIMER_CYCLES : 32'h0;
      if (ev[0] || r_reg.st == rcss_pkg::ST_BOOT) begin
        r_next.dly = 32'(POR_CYCLES + powerup_timer);
        r_next.kind = 3'h1;
      end else if (ev[1]) begin
        r_next.dly = powerup_timer;
        r_next.kind = 3'h2;
      end else begin
        r_next.dly = 32'h0;
        r_next.kind = 3'h4;
      end
      r_next.cur = src;
      r_next.st = rcss_pkg::ST_RST;
      r_next.rst_out = 1'b1;
      r_next.run = 1'b0;
      r_next.mon = 1'b0;
      r_next.mdly = MON_CYCLES;
      r_next.osc_startup_timer = '0;
      r_next.ost_done = !xtal_of(src, primary_submode_cfg_i);
      r_next.req = 1'b0;
      r_next.lock = 1'b0;
      r_next.cfail = 1'b0;
      r_next.arm_hi = 1'b0;
      r_next.arm_lo = 1'b0;
    end

    // oscillator enables: current, target while switching, and kept sources
    sw_nx = (r_next.st == rcss_pkg::ST_SW_OST) || (r_next.st == rcss_pkg::ST_SW_LOCK) ||
      (r_next.st == rcss_pkg::ST_SW_SET);
    r_next.osc_en = fam_of(r_next.cur) | (sw_nx ? fam_of(r_next.nsel) : 4'h0);
    r_next.osc_en[rcss_pkg::FAM_SLOW] = r_next.osc_en[rcss_pkg::FAM_SLOW] ||
      wdt_uses_slow_rc_i || rtc_uses_slow_rc_i || r_next.mon;
    r_next.osc_en[rcss_pkg::FAM_SEC] = r_next.osc_en[rcss_pkg::FAM_SEC] ||
      r_next.sec_en;
    r_next.pll_en = pll_of(r_next.cur) || (sw_nx && pll_of(r_next.nsel));
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r_reg <= '0;
      r_reg.st <= rcss_pkg::ST_BOOT;
      r_reg.rst_out <= 1'b1;
      r_reg.osc_en <= 4'h1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign system_reset_out_o = r_reg.rst_out;
  assign exec_enable_o = r_reg.run;
  assign clock_fail_monitor_en_o = r_reg.mon;
  assign sys_clk_sel_o = r_reg.cur;
  assign osc_enable_o = r_reg.osc_en;
  assign pll_enable_o = r_reg.pll_en;
  assign prdata_o = r_reg.prdata;
  assign pready_o = r_reg.pready;
  assign pslverr_o = r_reg.pslverr;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_req_off;
    switch_monitor_cfg_i && acc && !r_reg.pready && paddr_i == rcss_pkg::ADDR_CTRL
      |=> !prdata_o[rcss_pkg::REQ_BIT];
  endproperty
  a_req_off: assert property (p_req_off) else $error("request reads 1 while disabled");

  property p_same_abort;
    r_reg.st == rcss_pkg::ST_RUN && r_reg.req && sw_en && r_reg.nsel == r_reg.cur &&
      !ev_any && !wr_done |=> !r_reg.req && r_reg.st == rcss_pkg::ST_RUN;
  endproperty
  a_same_abort: assert property (p_same_abort) else $error("redundant switch not aborted");

  property p_start_clear;
    r_reg.st == rcss_pkg::ST_RUN && r_next.st == rcss_pkg::ST_SW_OST
      |=> !r_reg.lock && !r_reg.cfail;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("lock not cleared");

  property p_change;
    r_reg.st == rcss_pkg::ST_SW_SET && r_next.st == rcss_pkg::ST_RUN
      |=> r_reg.cur == $past(r_reg.nsel) && !r_reg.req;
  endproperty
  a_change: assert property (p_change) else $error("changeover did not update");

  property p_settle;
    r_reg.st == rcss_pkg::ST_SW_SET && r_next.st == rcss_pkg::ST_RUN
      |-> r_reg.settle == rcss_pkg::SETTLE_LAST && tk_hit;
  endproperty
  a_settle: assert property (p_settle) else $error("changeover before ten ticks");

  property p_release;
    $fell(r_reg.rst_out) |-> $past(r_reg.dly) == 32'h0 && $past(r_reg.st) == rcss_pkg::ST_RST;
  endproperty
  a_release: assert property (p_release) else $error("reset out released early");

  property p_exec;
    $rose(r_reg.run) |-> !$past(r_reg.rst_out) && $past(r_reg.ost_done);
  endproperty
  a_exec: assert property (p_exec) else $error("execution began too early");

  property p_mon;
    r_reg.mon |-> !r_reg.rst_out && !switch_monitor_cfg_i;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor active out of order");

  property p_ost;
    !r_reg.ost_done && r_next.ost_done && !ev_any |-> r_reg.osc_startup_timer == rcss_pkg::OST_LAST && tk_hit;
  endproperty
  a_ost: assert property (p_ost) else $error("startup timer ended early");

  property p_unlock;
    wr_done && paddr_i == rcss_pkg::ADDR_CTRL && pstrb_i[1] && !r_reg.arm_hi
      |=> r_reg.nsel == $past(r_reg.nsel);
  endproperty
  a_unlock: assert property (p_unlock) else $error("locked byte was written");

  property p_keep_slow;
    wdt_uses_slow_rc_i |=> osc_enable_o[rcss_pkg::FAM_SLOW];
  endproperty
  a_keep_slow: assert property (p_keep_slow) else $error("slow rc stopped in use");

endmodule : rcss_top

// *** rcss_pkg.sv ***
// rcss_pkg: constants, encodings and state types of the reset clock select and switch block
package rcss_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned POWERUP_TIMER_MS = 64;
  localparam int unsigned POWERUP_TIMER_CYC = 32'(64'(POWERUP_TIMER_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam int unsigned POR_US = 10;
  localparam int unsigned POR_CYC = 32'((64'(POR_US) * 64'(CLK_HZ) + 64'd999_999) / 64'd1_000_000);
  localparam int unsigned MON_US = 4;
  localparam int unsigned MON_CYC = 32'((64'(MON_US) * 64'(CLK_HZ) + 64'd999_999) / 64'd1_000_000);
  localparam logic [9:0] OST_LAST = 10'h3FF;
  localparam logic [3:0] SETTLE_LAST = 4'h9;

  // ************************************************************
  // clock sources, families and primary submodes
  // ************************************************************
  localparam logic [2:0] SRC_FAST = 3'h0;
  localparam logic [2:0] SRC_FAST_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_SEC = 3'h4;
  localparam logic [2:0] SRC_SLOW = 3'h5;
  localparam logic [2:0] SRC_FAST_DIV = 3'h7;
  localparam int FAM_FAST = 0;
  localparam int FAM_PRI = 1;
  localparam int FAM_SEC = 2;
  localparam int FAM_SLOW = 3;
  localparam logic [1:0] SUB_EC = 2'h0;
  localparam logic [1:0] SUB_XT = 2'h1;
  localparam logic [1:0] SUB_HS = 2'h2;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_UNLOCK = 12'h004;
  localparam logic [11:0] ADDR_STAT = 12'h008;
  localparam logic [31:0] KEY_HI = 32'h0000_5A5A;
  localparam logic [31:0] KEY_LO = 32'h0000_A5A5;
  localparam int CUR_LSB = 12;
  localparam int NEW_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SEC_BIT = 1;
  localparam int REQ_BIT = 0;
  localparam int STAT_KIND_LSB = 4;
  localparam int STAT_FSM_LSB = 8;

  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_RST = 3'h1,
    ST_RUN = 3'h2,
    ST_SW_OST = 3'h3,
    ST_SW_LOCK = 3'h4,
    ST_SW_SET = 3'h5
  } rcss_state_t;

  typedef struct packed {
    logic [4:0] rst_s1;
    logic [4:0] rst_s2;
    logic [4:0] rst_d;
    logic [3:0] tk_s1;
    logic [3:0] tk_s2;
    logic [3:0] tk_d;
    logic lk_s1;
    logic lk_s2;
    logic fl_s1;
    logic fl_s2;
    rcss_state_t st;
    logic [31:0] dly;
    logic [31:0] mdly;
    logic [9:0] osc_startup_timer;
    logic ost_done;
    logic [3:0] settle;
    logic [2:0] cur;
    logic [2:0] nsel;
    logic lock;
    logic cfail;
    logic sec_en;
    logic req;
    logic arm_hi;
    logic arm_lo;
    logic rst_out;
    logic run;
    logic mon;
    logic [3:0] osc_en;
    logic pll_en;
    logic [2:0] kind;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rcss_regs_t;

endpackage : rcss_pkg

// *** rcss_top_tb_top.sv ***
// rcss_top_tb_top: self-checking bench for the reset clock select and switch block
module rcss_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // *****
  // stimulus, shortened delays and outputs
  // *****
  localparam int POWERUP_TIMER = 50;
  localparam int PORC = 20;
  localparam int MONC = 10;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [4:0] cause = 5'h00; // power-on, brown-out, pin, watchdog, software
  logic mon_cfg = 1'b0;
  logic powerup_timer_en = 1'b1;
  logic two_speed = 1'b0;
  logic [3:0] ticks = 4'h0;
  logic clk_fail = 1'b0;
  logic wdt_slow = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic rst_out, exec_en, mon_en, pll_en, pready_o, pslverr_o;
  logic [2:0] sel;
  logic [3:0] osc_en;
  logic [31:0] prdata_o;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;

  rcss_top #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER), .POR_CYCLES(PORC), .MON_CYCLES(MONC)) u_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .power_on_rst_i(cause[0]), .brownout_reset_i(cause[1]), .external_reset_pin_i(cause[2]),
    .watchdog_timeout_reset_i(cause[3]), .software_reset_i(cause[4]),
    .switch_monitor_cfg_i(mon_cfg), .initial_osc_select_cfg_i(rcss_pkg::SRC_PRI),
    .primary_submode_cfg_i(rcss_pkg::SUB_XT), .powerup_timer_en_cfg_i(powerup_timer_en),
    .two_speed_cfg_i(two_speed), .osc_tick_i(ticks), .pll_lock_i(1'b1),
    .clock_fail_i(clk_fail), .wdt_uses_slow_rc_i(wdt_slow), .rtc_uses_slow_rc_i(1'b0),
    .system_reset_out_o(rst_out), .exec_enable_o(exec_en), .clock_fail_monitor_en_o(mon_en),
    .sys_clk_sel_o(sel), .osc_enable_o(osc_en), .pll_enable_o(pll_en),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o));

  // clock; every oscillator ticks at half rate, so 1024 periods span 2048 cycles
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    ticks <= ~ticks;
  end
  // hang guard, well above the ~3000 cycles the run needs
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      end_sim();
    end
  end

  // *****
  // shared tasks
  // *****
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    q = prdata_o;
    e = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, 32'(n < 16));
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, s, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic e);
    apb(1'b0, a, 32'h0000_0000, 4'h0, q, e);
  endtask : rd
  // unlock, new select, unlock, request; bit 3 written as 1 leaves the fail flag alone
  task automatic request(input logic [2:0] src);
    wr(rcss_pkg::ADDR_UNLOCK, rcss_pkg::KEY_HI, 4'hF);
    wr(rcss_pkg::ADDR_CTRL, {21'h000000, src, 8'h00}, 4'h2);
    wr(rcss_pkg::ADDR_UNLOCK, rcss_pkg::KEY_LO, 4'hF);
    wr(rcss_pkg::ADDR_CTRL, 32'h0000_0009, 4'h1);
  endtask : request
  // raise one reset cause and count the cycles system reset stays high
  task automatic rst_evt(input int idx, output int hi);
    int n;
    @(posedge clk_i);
    cause[idx] <= 1'b1;
    n = 0;
    while (rst_out !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    hi = 0;
    while (rst_out === 1'b1 && hi < 5000) begin
      @(posedge clk_i);
      hi++;
    end
    cause[idx] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : rst_evt

  // *****
  // scenarios
  // *****
  task automatic t_boot;
    int tr, tx, tm;
    tr = -1;
    tx = -1;
    tm = -1;
    for (int i = 0; i < 2300; i++) begin
      @(posedge clk_i);
      if (tr < 0 && rst_out === 1'b0) tr = i;
      if (tx < 0 && exec_en === 1'b1) tx = i;
      if (tm < 0 && mon_en === 1'b1) tm = i;
    end
    chk("release_time", 32'h1, 32'(tr >= PORC + POWERUP_TIMER && tr <= PORC + POWERUP_TIMER + 6));
    chk("exec_time", 32'h1, 32'(tx >= 2044 && tx <= 2080));
    chk("monitor_time", 32'h1, 32'(tm - tr >= MONC && tm - tr <= MONC + 4));
    chk("boot_sel", {29'h0, rcss_pkg::SRC_PRI}, {29'h0, sel});
  endtask : t_boot
  task automatic t_locked;
    logic [31:0] q0, q1;
    logic e;
    rd(rcss_pkg::ADDR_CTRL, q0, e);
    wr(rcss_pkg::ADDR_CTRL, 32'h0000_0500, 4'h2);
    wr(rcss_pkg::ADDR_CTRL, 32'h0000_0009, 4'h1);
    rd(rcss_pkg::ADDR_CTRL, q1, e);
    chk("locked_new", {29'h0, q0[10:8]}, {29'h0, q1[10:8]});
    chk("locked_req", 32'h0, {31'h0, q1[0]});
    wr(rcss_pkg::ADDR_UNLOCK, rcss_pkg::KEY_HI, 4'hF);
    wr(rcss_pkg::ADDR_CTRL, 32'h0000_0500, 4'h2);
    wr(rcss_pkg::ADDR_CTRL, 32'h0000_0400, 4'h2);
    rd(rcss_pkg::ADDR_CTRL, q1, e);
    chk("one_write", 32'h5, {29'h0, q1[10:8]});
    rd(12'h010, q1, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
  endtask : t_locked
  task automatic t_switch;
    logic [31:0] q;
    logic e;
    int n;
    clk_fail <= 1'b1;
    repeat (6) @(posedge clk_i);
    clk_fail <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(rcss_pkg::ADDR_CTRL, q, e);
    chk("fail_set", 32'h1, {31'h0, q[rcss_pkg::FAIL_BIT]});
    request(rcss_pkg::SRC_FAST);
    rd(rcss_pkg::ADDR_CTRL, q, e);
    chk("fail_cleared", 32'h0, {31'h0, q[rcss_pkg::FAIL_BIT]});
    n = 0;
    while (q[rcss_pkg::REQ_BIT] !== 1'b0 && n < 40) begin
      rd(rcss_pkg::ADDR_CTRL, q, e);
      n++;
    end
    chk("req_done", 32'h0, {31'h0, q[rcss_pkg::REQ_BIT]});
    chk("cur_field", 32'h0, {29'h0, q[14:12]});
    chk("sel_new", 32'h0, {29'h0, sel});
    chk("old_off", 32'h0, {31'h0, osc_en[1]});
    chk("exec_kept", 32'h1, {31'h0, exec_en});
    request(rcss_pkg::SRC_FAST);
    rd(rcss_pkg::ADDR_CTRL, q, e);
    chk("redundant_req", 32'h0, {31'h0, q[rcss_pkg::REQ_BIT]});
    chk("redundant_sel", 32'h0, {29'h0, sel});
  endtask : t_switch
  task automatic t_resets;
    int hi;
    for (int k = 2; k < 5; k++) begin
      rst_evt(k, hi);
      chk("other_delay", 32'h1, 32'(hi <= 4));
      chk("other_sel", 32'h0, {29'h0, sel});
    end
    rst_evt(1, hi);
    chk("bor_delay", 32'h1, 32'(hi >= POWERUP_TIMER && hi <= POWERUP_TIMER + 4));
    chk("bor_sel", {29'h0, rcss_pkg::SRC_PRI}, {29'h0, sel});
    powerup_timer_en <= 1'b0;
    rst_evt(1, hi);
    chk("bor_no_powerup_timer", 32'h1, 32'(hi <= 4));
  endtask : t_resets
  task automatic t_disabled;
    logic [31:0] q;
    logic e;
    int hi;
    mon_cfg <= 1'b1;
    two_speed <= 1'b1;
    rst_evt(0, hi);
    chk("por_delay", 32'h1, 32'(hi >= PORC && hi <= PORC + 4));
    chk("two_speed_sel", 32'h0, {29'h0, sel});
    repeat (MONC + 10) @(posedge clk_i);
    chk("monitor_off", 32'h0, {31'h0, mon_en});
    request(rcss_pkg::SRC_SLOW);
    rd(rcss_pkg::ADDR_CTRL, q, e);
    chk("req_reads_0", 32'h0, {31'h0, q[rcss_pkg::REQ_BIT]});
    repeat (40) @(posedge clk_i);
    chk("no_switch", 32'h0, {29'h0, sel});
    chk("slow_idle", 32'h0, {31'h0, osc_en[rcss_pkg::FAM_SLOW]});
    wdt_slow <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("slow_kept", 32'h1, {31'h0, osc_en[rcss_pkg::FAM_SLOW]});
    two_speed <= 1'b0;
    rst_evt(3, hi);
    chk("cfg_sel", {29'h0, rcss_pkg::SRC_PRI}, {29'h0, sel});
  endtask : t_disabled

  // *****
  // main sequence and verdict
  // *****
  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_boot();
    t_locked();
    t_switch();
    t_resets();
    t_disabled();
    end_sim();
  end
endmodule : rcss_top_tb_top
